// ### shared/abs_pkg.sv
// shared constants and types for the avb byte stream port
package abs_pkg;
	localparam int ABS_DATA_W = 8;
	typedef logic [ABS_DATA_W-1:0] abs_byte_type;
	localparam abs_byte_type ABS_BYTE_RST = 8'h00;
	localparam int ABS_GIG_CLK_MHZ = 125;
	localparam int ABS_FAST_CLK_MHZ = 25;
	localparam int ABS_REF_CLK_MHZ = 25;
	localparam int ABS_FAST_CE_DIV = (ABS_REF_CLK_MHZ * 2) / ABS_FAST_CLK_MHZ;
	localparam int ABS_DIV_W = 2;
	localparam logic [ABS_DIV_W-1:0] ABS_DIV_RST = 2'h0;
	localparam logic [ABS_DIV_W-1:0] ABS_DIV_ONE = 2'h1;
	localparam logic [ABS_DIV_W-1:0] ABS_DIV_TERM = ABS_DIV_W'(ABS_FAST_CE_DIV - 1);
	typedef enum logic [1:0] {
		ABS_TX_IDLE = 2'b00,
		ABS_TX_WAIT = 2'b01,
		ABS_TX_RUN = 2'b10
	} abs_tx_state_type;
	typedef enum logic [2:0] {
		ABS_RX_IDLE = 3'b000,
		ABS_RX_BODY = 3'b001,
		ABS_RX_DROP = 3'b010,
		ABS_RX_VERDICT = 3'b011,
		ABS_RX_TAIL = 3'b100
	} abs_rx_state_type;
endpackage : abs_pkg

// ### shared/abs_stream_if.sv
// byte stream link between the mac port and the framing logic
`timescale 1ns/1ns
interface abs_stream_if;
	import abs_pkg::*;
	logic tx_ce;
	abs_byte_type tx_tdata;
	logic tx_tvalid;
	logic tx_tready;
	logic tx_tlast;
	logic tx_tuser;
	logic rx_ce;
	abs_byte_type rx_tdata;
	logic rx_tvalid;
	logic rx_tlast;
	logic rx_tuser;
	modport dev (
		output tx_ce, tx_tready, rx_ce, rx_tdata, rx_tvalid, rx_tlast, rx_tuser,
		input tx_tdata, tx_tvalid, tx_tlast, tx_tuser
	);
	modport host (
		input tx_ce, tx_tready, rx_ce, rx_tdata, rx_tvalid, rx_tlast, rx_tuser,
		output tx_tdata, tx_tvalid, tx_tlast, tx_tuser
	);
endinterface : abs_stream_if

// ### logic/abs_host_end.sv
// framing logic end of the byte stream link
`timescale 1ns/1ns
module abs_host_end (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	abs_stream_if.host link,
	input wire logic user_tx_avail_i,
	input wire abs_pkg::abs_byte_type user_tx_data_i,
	input wire logic user_tx_last_i,
	input wire logic user_tx_err_i,
	output logic user_tx_take_o,
	output abs_pkg::abs_byte_type user_rx_data_o,
	output logic user_rx_valid_o,
	output logic user_rx_last_o,
	output logic user_rx_err_o
);
	import abs_pkg::*;
	abs_byte_type tdata_r;
	logic tvalid_r;
	logic tlast_r;
	logic tuser_r;
	logic moved;
	logic load;

	assign moved = tvalid_r & link.tx_tready;
	assign load = user_tx_avail_i & (~tvalid_r | moved);
	assign user_tx_take_o = load;

	assign link.tx_tdata = tdata_r;
	assign link.tx_tvalid = tvalid_r;
	assign link.tx_tlast = tlast_r;
	assign link.tx_tuser = tuser_r;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			tdata_r <= ABS_BYTE_RST;
			tlast_r <= 1'b0;
			tuser_r <= 1'b0;
		end else if (load) begin
			tdata_r <= user_tx_data_i;
			tlast_r <= user_tx_last_i;
			tuser_r <= user_tx_err_i;
		end else if (moved) begin
			tlast_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			tvalid_r <= 1'b0;
		end else if (load) begin
			tvalid_r <= 1'b1;
		end else if (moved && tlast_r) begin
			tvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			user_rx_data_o <= ABS_BYTE_RST;
			user_rx_valid_o <= 1'b0;
			user_rx_last_o <= 1'b0;
			user_rx_err_o <= 1'b0;
		end else begin
			user_rx_valid_o <= link.rx_tvalid;
			user_rx_last_o <= link.rx_tvalid & link.rx_tlast;
			user_rx_err_o <= link.rx_tvalid & link.rx_tlast & link.rx_tuser;
			if (link.rx_tvalid) begin
				user_rx_data_o <= link.rx_tdata;
			end
		end
	end
endmodule : abs_host_end

// ### logic/abs_dev_end.sv
// mac end of the avb byte stream link
`timescale 1ns/1ns
module abs_dev_end (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	abs_stream_if.dev link,
	input wire logic mac_up_i,
	input wire logic speed_gig_i,
	input wire logic mac_tx_started_i,
	output abs_pkg::abs_byte_type mac_tx_data_o,
	output logic mac_tx_valid_o,
	output logic mac_tx_first_o,
	output logic mac_tx_last_o,
	output logic mac_tx_err_o,
	input wire logic mac_rx_valid_i,
	input wire logic mac_rx_first_i,
	input wire logic mac_rx_last_i,
	input wire abs_pkg::abs_byte_type mac_rx_data_i,
	input wire logic mac_rx_pass_i,
	input wire logic mac_rx_good_i,
	input wire logic mac_rx_bad_i
);
	import abs_pkg::*;
	logic [ABS_DIV_W-1:0] tx_div_r;
	logic [ABS_DIV_W-1:0] rx_div_r;
	logic tx_ce_r;
	logic rx_ce_r;
	logic live_r;
	abs_tx_state_type tx_state_r;
	abs_tx_state_type tx_state_nxt;
	logic tx_ready;
	logic tx_take;
	logic tx_err_r;
	abs_rx_state_type rx_state_r;
	abs_rx_state_type rx_state_nxt;
	logic rx_byte;
	abs_byte_type hold_r;
	logic verdict_r;
	logic bad_r;
	logic verdict_in;
	logic tail_go;
	abs_byte_type rx_tdata_r;
	logic rx_tvalid_r;
	logic rx_tlast_r;
	logic rx_tuser_r;

	function automatic logic div_wrap(input logic [ABS_DIV_W-1:0] cnt);
		div_wrap = (cnt == ABS_DIV_TERM);
	endfunction : div_wrap

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			tx_div_r <= ABS_DIV_RST;
			tx_ce_r <= 1'b0;
		end else begin
			tx_div_r <= div_wrap(tx_div_r) ? ABS_DIV_RST : tx_div_r + ABS_DIV_ONE;
			tx_ce_r <= speed_gig_i | div_wrap(tx_div_r);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			rx_div_r <= ABS_DIV_RST;
			rx_ce_r <= 1'b0;
		end else begin
			rx_div_r <= div_wrap(rx_div_r) ? ABS_DIV_RST : rx_div_r + ABS_DIV_ONE;
			rx_ce_r <= speed_gig_i | div_wrap(rx_div_r);
		end
	end

	assign link.tx_ce = tx_ce_r;
	assign link.rx_ce = rx_ce_r;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			live_r <= 1'b0;
		end else begin
			live_r <= mac_up_i;
		end
	end

	always_comb begin
		tx_ready = 1'b0;
		case (tx_state_r)
			ABS_TX_IDLE: tx_ready = live_r & tx_ce_r;
			ABS_TX_RUN: tx_ready = tx_ce_r;
			default: tx_ready = 1'b0;
		endcase
	end
	assign link.tx_tready = tx_ready;
	assign tx_take = tx_ready & link.tx_tvalid;

	always_comb begin
		tx_state_nxt = tx_state_r;
		case (tx_state_r)
			ABS_TX_IDLE: begin
				if (tx_take) begin
					tx_state_nxt = link.tx_tlast ? ABS_TX_IDLE : ABS_TX_WAIT;
				end
			end
			ABS_TX_WAIT: begin
				if (mac_tx_started_i) begin
					tx_state_nxt = ABS_TX_RUN;
				end
			end
			ABS_TX_RUN: begin
				if (tx_take && link.tx_tlast) begin
					tx_state_nxt = ABS_TX_IDLE;
				end
			end
			default: tx_state_nxt = ABS_TX_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			tx_state_r <= ABS_TX_IDLE;
		end else begin
			tx_state_r <= tx_state_nxt;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			tx_err_r <= 1'b0;
		end else if (tx_take) begin
			tx_err_r <= link.tx_tlast ? 1'b0 : (tx_err_r | link.tx_tuser);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			mac_tx_data_o <= ABS_BYTE_RST;
			mac_tx_valid_o <= 1'b0;
			mac_tx_first_o <= 1'b0;
			mac_tx_last_o <= 1'b0;
			mac_tx_err_o <= 1'b0;
		end else begin
			mac_tx_valid_o <= tx_take;
			mac_tx_first_o <= tx_take & (tx_state_r == ABS_TX_IDLE);
			mac_tx_last_o <= tx_take & link.tx_tlast;
			mac_tx_err_o <= tx_take & (tx_err_r | link.tx_tuser);
			if (tx_take) begin
				mac_tx_data_o <= link.tx_tdata;
			end
		end
	end

	assign rx_byte = mac_rx_valid_i & rx_ce_r;
	assign verdict_in = mac_rx_good_i | mac_rx_bad_i;
	assign tail_go = (rx_state_r == ABS_RX_TAIL) & rx_ce_r;

	always_comb begin
		rx_state_nxt = rx_state_r;
		case (rx_state_r)
			ABS_RX_IDLE: begin
				if (rx_byte && mac_rx_first_i && live_r) begin
					if (mac_rx_pass_i) begin
						rx_state_nxt = mac_rx_last_i ? ABS_RX_VERDICT : ABS_RX_BODY;
					end else if (!mac_rx_last_i) begin
						rx_state_nxt = ABS_RX_DROP;
					end
				end
			end
			ABS_RX_BODY: begin
				if (rx_byte && mac_rx_last_i) begin
					rx_state_nxt = ABS_RX_VERDICT;
				end
			end
			ABS_RX_DROP: begin
				if (rx_byte && mac_rx_last_i) begin
					rx_state_nxt = ABS_RX_IDLE;
				end
			end
			ABS_RX_VERDICT: begin
				if (verdict_r) begin
					rx_state_nxt = ABS_RX_TAIL;
				end
			end
			ABS_RX_TAIL: begin
				if (rx_ce_r) begin
					rx_state_nxt = ABS_RX_IDLE;
				end
			end
			default: rx_state_nxt = ABS_RX_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			rx_state_r <= ABS_RX_IDLE;
		end else begin
			rx_state_r <= rx_state_nxt;
		end
	end

	// one byte held back behind the mac
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			hold_r <= ABS_BYTE_RST;
		end else if (rx_byte && (rx_state_r == ABS_RX_IDLE || rx_state_r == ABS_RX_BODY)) begin
			hold_r <= mac_rx_data_i;
		end
	end

	// verdict capture, a new verdict beats the clear
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			verdict_r <= 1'b0;
			bad_r <= 1'b0;
		end else if (verdict_in) begin
			verdict_r <= 1'b1;
			bad_r <= mac_rx_bad_i;
		end else if (tail_go || (rx_byte && mac_rx_first_i && rx_state_r == ABS_RX_IDLE)) begin
			verdict_r <= 1'b0;
			bad_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			rx_tdata_r <= ABS_BYTE_RST;
			rx_tvalid_r <= 1'b0;
			rx_tlast_r <= 1'b0;
			rx_tuser_r <= 1'b0;
		end else begin
			rx_tvalid_r <= (rx_byte & (rx_state_r == ABS_RX_BODY)) | tail_go;
			rx_tlast_r <= tail_go;
			rx_tuser_r <= tail_go & bad_r;
			if ((rx_byte && rx_state_r == ABS_RX_BODY) || tail_go) begin
				rx_tdata_r <= hold_r;
			end
		end
	end

	assign link.rx_tdata = rx_tdata_r;
	assign link.rx_tvalid = rx_tvalid_r;
	assign link.rx_tlast = rx_tlast_r;
	assign link.rx_tuser = rx_tuser_r;
endmodule : abs_dev_end

// ### verif/abs_link_checker.sv
// assertions on the byte stream link between both ends
`timescale 1ns/1ns
module abs_link_checker (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic tx_ce,
	input wire logic tx_tvalid,
	input wire logic tx_tready,
	input wire logic tx_tlast,
	input wire logic rx_ce,
	input wire logic rx_tvalid,
	input wire logic rx_tlast,
	input wire logic rx_tuser
);
	logic in_frame_r;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || (tx_tvalid && tx_tready && tx_tlast))
			in_frame_r <= 1'b0;
		else if (tx_tvalid && tx_tready)
			in_frame_r <= 1'b1;
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_tx_ready_ce: assert property (tx_tready |-> tx_ce) else $error("tready without enable");
	a_tx_first_hold: assert property (tx_tvalid && tx_tready && !tx_tlast && !in_frame_r |=> !tx_tready)
		else $error("tready not held low after first byte");
	a_tx_ce_toggle: assert property ($past(rst_n_i) && !tx_ce && $past(tx_ce) |=> tx_ce)
		else $error("tx enable stuck low");
	a_rx_valid_ce: assert property (rx_tvalid |-> $past(rx_ce)) else $error("rx valid without enable");
	a_rx_last_valid: assert property (rx_tlast |-> rx_tvalid) else $error("tlast without valid");
	a_rx_tuser_last: assert property (rx_tuser |-> rx_tlast) else $error("tuser outside tlast");
	a_rx_last_gap: assert property (rx_tlast |-> !$past(rx_tvalid)) else $error("last byte not withheld");
	a_rst_quiet: assert property ($rose(rst_n_i) |-> !tx_tready && !rx_tvalid) else $error("busy after reset");
	a_tx_ce_gap: assert property ($past(rst_n_i) && !tx_ce |=> tx_ce) else $error("tx enable low twice");
	a_rx_last_single: assert property (rx_tlast |=> !rx_tvalid) else $error("last byte not single");
endmodule : abs_link_checker

// ### verif/tb_avb_byte_stream_port.sv
// self-checking bench joining both ends of the byte stream link
`timescale 1ns/1ns
module tb_avb_byte_stream_port;
	import abs_pkg::*;
	logic ref_clk, take, m_tv, m_tf, m_tl, m_te, u_rv, u_rl, u_re;
	logic rst_n = 0, mac_up = 0, gig = 1, started = 0, t_av = 0, t_last = 0, t_err = 0;
	logic r_v = 0, r_f = 0, r_l = 0, r_pass = 1, r_good = 0, r_bad = 0;
	abs_byte_type t_data = 8'h00, r_data = 8'h00, m_tdata, u_rdata;
	int n_fail = 0, check_count = 0;
	logic [10:0] txq[$], rxq[$];
	abs_stream_if lk();
	abs_dev_end abs_dev_end_i (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .link(lk), .mac_up_i(mac_up), .speed_gig_i(gig),
		.mac_tx_started_i(started), .mac_tx_data_o(m_tdata), .mac_tx_valid_o(m_tv), .mac_tx_first_o(m_tf),
		.mac_tx_last_o(m_tl), .mac_tx_err_o(m_te), .mac_rx_valid_i(r_v), .mac_rx_first_i(r_f), .mac_rx_last_i(r_l),
		.mac_rx_data_i(r_data), .mac_rx_pass_i(r_pass), .mac_rx_good_i(r_good), .mac_rx_bad_i(r_bad));
	abs_host_end abs_host_end_i (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .link(lk), .user_tx_avail_i(t_av),
		.user_tx_data_i(t_data), .user_tx_last_i(t_last), .user_tx_err_i(t_err), .user_tx_take_o(take),
		.user_rx_data_o(u_rdata), .user_rx_valid_o(u_rv), .user_rx_last_o(u_rl), .user_rx_err_o(u_re));
	abs_link_checker abs_link_checker_i (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .tx_ce(lk.tx_ce),
		.tx_tvalid(lk.tx_tvalid), .tx_tready(lk.tx_tready), .tx_tlast(lk.tx_tlast), .rx_ce(lk.rx_ce),
		.rx_tvalid(lk.rx_tvalid), .rx_tlast(lk.rx_tlast), .rx_tuser(lk.rx_tuser));
	initial begin
		ref_clk = 0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(negedge ref_clk) begin
		if (m_tv === 1'b1)
			txq.push_back({m_tf, m_te, m_tl, m_tdata});
		if (u_rv === 1'b1)
			rxq.push_back({1'b0, u_re, u_rl, u_rdata});
	end
	task automatic check(input logic [10:0] seen, input logic [10:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	task automatic do_reset(input logic g);
		@(negedge ref_clk);
		rst_n = 0;
		mac_up = 0;
		gig = g;
		repeat (20) @(negedge ref_clk);
		rst_n = 1;
		repeat (3) begin
			@(negedge ref_clk);
			check(11'({lk.tx_tready, lk.rx_tvalid}), 11'h000);
		end
		mac_up = 1;
		repeat (3) @(negedge ref_clk);
	endtask : do_reset
	// frame through host user side, mac start delayed to hold the stream
	task automatic test_tx(input int n);
		int i;
		int w;
		logic tk;
		i = 0;
		w = 0;
		tk = 0;
		txq.delete();
		while (i < n && w < 400) begin
			@(negedge ref_clk);
			if (tk)
				i++;
			w++;
			t_av = (i < n);
			t_data = 8'h10 + i[7:0];
			t_last = (i == n - 1);
			t_err = (i == 1);
			started = (w > 8);
			#1 tk = take;
		end
		t_av = 0;
		started = 0;
		repeat (6) @(negedge ref_clk);
		check(11'(txq.size()), 11'(n));
		foreach (txq[k]) check(txq[k], {k == 0, k >= 1, k == n - 1, 8'h10 + k[7:0]});
		$display("tx test of %0d bytes done", n);
	endtask : test_tx
	// frame from mac side, verdict given a few cycles after the last byte
	task automatic test_rx(input int n, input logic bad, input logic pass);
		int i;
		i = 0;
		rxq.delete();
		r_pass = pass;
		while (i < n) begin
			@(negedge ref_clk);
			r_v = lk.rx_ce;
			r_f = (i == 0);
			r_l = (i == n - 1);
			r_data = 8'h40 + i[7:0];
			if (lk.rx_ce)
				i++;
		end
		@(negedge ref_clk);
		r_v = 0;
		repeat (3) @(negedge ref_clk);
		r_good = !bad;
		r_bad = bad;
		@(negedge ref_clk);
		r_good = 0;
		r_bad = 0;
		repeat (12) @(negedge ref_clk);
		check(11'(rxq.size()), pass ? 11'(n) : 11'h000);
		foreach (rxq[k]) check(rxq[k], {1'b0, bad && k == n - 1, k == n - 1, 8'h40 + k[7:0]});
		$display("rx test of %0d bytes done", n);
	endtask : test_rx
	initial begin
		#(40 * 20000);
		n_fail++;
		conclude();
	end
	initial begin
		do_reset(1'b1);
		test_tx(5);
		test_tx(1);
		test_rx(4, 1'b0, 1'b1);
		test_rx(3, 1'b1, 1'b0);
		do_reset(1'b0);
		test_tx(4);
		test_rx(4, 1'b1, 1'b1);
		conclude();
	end
endmodule : tb_avb_byte_stream_port
